/* File: logic/fp_exec_timer.sv */
// floating-point execution timer with interrupt abort and restart
// assumes decode supplies base microcycles and data attributes,
// and the interrupt logic shares this clock
`include "fpt_cfg.svh"
`default_nettype none
module fp_exec_timer
    import fpt_pkg::*;
#(
    parameter int unsigned CHK_UC = `CHK_UC_DEF,
    parameter int unsigned DIV = `UCYC_CLKS
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire fpt_pkg::op_class_e op_class,
    input wire logic dbl,
    input wire logic [2:0] addr_mode,
    input wire logic [7:0] mem_uc,
    input wire fpt_pkg::uc_t base_uc,
    input wire fpt_pkg::sign_case_e sign_case,
    input wire logic undefined_variable_trap_flag,
    input wire logic round_ovf,
    input wire logic rounding,
    input wire logic [7:0] exp_diff,
    input wire fpt_pkg::word_t fp_source_operand,
    input wire fpt_pkg::word_t fp_accumulator_operand,
    input wire logic [5:0] norm_shifts,
    input wire logic cmp_equal,
    input wire logic trap_any,
    input wire logic trap_conv,
    input wire logic trap_underflow,
    input wire logic irq_req,
    input wire logic svc_done,
    output logic busy,
    output logic done,
    output logic aborted,
    output logic restored,
    output logic restart,
    output logic irq_ack,
    output fpt_pkg::word_t restore_acc,
    output fpt_pkg::word_t restore_src,
    output fpt_pkg::uc_t total_uc,
    output fpt_pkg::uc_t lat_uc
);
    import fpt_pkg::*;

    // ********************************************************
    // constants and checks
    // ********************************************************
    localparam uc_t CHK = uc_t'(CHK_UC);
    localparam uc_t RESTORE_UC = uc_t'(`NS2UC(`T_RESTORE_NS));
    localparam int RST_CLKS = `NS2UC(`T_RESTORE_NS) * DIV;

    if (CHK_UC < 1 || CHK_UC > 4000 || DIV < 1) begin : g_chk
        $error("fp_exec_timer: CHK_UC or DIV out of range");
    end

    // ********************************************************
    // state
    // ********************************************************
    typedef struct packed {
        seq_state_e st;
        logic arith;
        uc_t uc_left;
        uc_t chk_left;
        uc_t total;
        uc_t lat;
        word_t acc_save;
        word_t src_save;
        logic done;
        logic aborted;
        logic restored;
        logic restart;
        logic irq_ack;
    } seq_s;

    localparam seq_s SEQ_RST = '{st: ST_IDLE, default: '0};

    seq_s s_ff;
    seq_s nxt_s;
    op_info_s oi;
    ucycle_if tif ();

    ucycle_timer #(
        .DIV(DIV)
    ) u_tmr (
        .clk(clk),
        .rst_n(rst_n),
        .tif(tif)
    );

    // ********************************************************
    // functions
    // ********************************************************

    // instructions that may be interrupted part way
    function automatic logic is_arith(op_class_e op);
        return op inside {OP_ADD, OP_SUB, OP_MUL, OP_DIV, OP_MOD};
    endfunction

    // whole instruction length in microcycles
    function automatic uc_t calc_uc(op_info_s o);
        logic [15:0] t;
        t = 16'(o.base_uc);
        if (o.mode != 3'h0) begin
            t = t + 16'(o.mem_uc);
        end
        // three sign cases; negative zero adds only via trap
        case (o.sign)
            SG_POS: t = t + 16'(`NS2UC(`T_POS_NS)) + 16'(`NS2UC(`T_NZ_NS));
            SG_NEG_NZ: t = t + 16'(`NS2UC(`T_NZ_NS));
            SG_NEG_ZERO: begin
                if (o.undef_flag) begin
                    t = t + 16'(`NS2UC(`T_UNDEF_NS));
                end
            end
            default: ;
        endcase
        if (o.round_ovf && (o.op == OP_LOAD || o.op == OP_CONV)) begin
            t = t + 16'(`NS2UC(`T_RNDOVF_NS));
        end
        // single precision increments
        if (!o.dbl) begin
            if (o.op == OP_ADD || o.op == OP_SUB) begin
                t = t + 16'(`NS2UC(`T_ALIGN_NS));
                t = t + 16'(`NS2UC(`T_ALIGN_STEP_NS)) * 16'(o.exp_diff);
            end
            if (o.op == OP_MUL) begin
                for (int i = 0; i < 16; i++) begin
                    if (o.src[i]) begin
                        t = t + 16'(`NS2UC(`T_MULBIT_NS));
                    end
                end
            end
            t = t + 16'(`NS2UC(`T_NORM_NS)) * 16'(o.shifts);
            if (o.rounding) begin
                t = t + 16'(`NS2UC(`T_ROUND_NS));
            end
        end
        if (o.op == OP_CMP && o.cmp_equal) begin
            t = t + 16'(`NS2UC(`T_CMPEQ_NS));
        end
        if (o.trap_any) begin
            t = t + 16'(`NS2UC(`T_TRAP_NS));
        end
        if (o.op == OP_CONV && o.trap_conv) begin
            t = t + 16'(`NS2UC(`T_CONVERR_NS));
        end
        if (is_arith(o.op) && o.trap_unfl) begin
            t = t + 16'(`NS2UC(`T_UNFL_NS));
        end
        // never zero, saturate at the counter range
        if (t == 16'h0000) begin
            t = 16'h0001;
        end
        if (t > 16'(`UC_MAX)) begin
            t = 16'(`UC_MAX);
        end
        return t[11:0];
    endfunction

    // ********************************************************
    // operand bundle
    // ********************************************************
    always_comb begin
        oi.op = op_class;
        oi.dbl = dbl;
        oi.mode = addr_mode;
        oi.mem_uc = mem_uc;
        oi.base_uc = base_uc;
        oi.sign = sign_case;
        oi.undef_flag = undefined_variable_trap_flag;
        oi.round_ovf = round_ovf;
        oi.rounding = rounding;
        oi.exp_diff = exp_diff;
        oi.src = fp_source_operand;
        oi.shifts = norm_shifts;
        oi.cmp_equal = cmp_equal;
        oi.trap_any = trap_any;
        oi.trap_conv = trap_conv;
        oi.trap_unfl = trap_underflow;
    end

    // ********************************************************
    // sequencer
    // ********************************************************

    // timer runs while executing or restoring
    assign tif.run = (s_ff.st == ST_EXEC) || (s_ff.st == ST_RESTORE);

    // next state: one process for the whole sequencer
    always_comb begin
        nxt_s = s_ff;
        nxt_s.done = 1'b0;
        nxt_s.aborted = 1'b0;
        nxt_s.restored = 1'b0;
        nxt_s.restart = 1'b0;
        nxt_s.irq_ack = 1'b0;
        case (s_ff.st)
            ST_IDLE: begin
                if (start) begin
                    nxt_s.st = ST_EXEC;
                    nxt_s.arith = is_arith(op_class);
                    nxt_s.total = calc_uc(oi);
                    nxt_s.uc_left = calc_uc(oi);
                    nxt_s.chk_left = CHK;
                    nxt_s.acc_save = fp_accumulator_operand;
                    nxt_s.src_save = fp_source_operand;
                    if (is_arith(op_class)) begin
                        nxt_s.lat = CHK + RESTORE_UC;
                    end else begin
                        nxt_s.lat = calc_uc(oi);
                    end
                end
            end
            ST_EXEC: begin
                if (tif.tick) begin
                    if (s_ff.uc_left == 12'h001) begin
                        nxt_s.st = ST_IDLE;
                        nxt_s.done = 1'b1;
                        nxt_s.irq_ack = irq_req;
                    end else begin
                        nxt_s.uc_left = s_ff.uc_left - 12'h001;
                        if (s_ff.chk_left == 12'h001) begin
                            nxt_s.chk_left = CHK;
                            if (s_ff.arith && irq_req) begin
                                nxt_s.st = ST_RESTORE;
                                nxt_s.aborted = 1'b1;
                                nxt_s.uc_left = RESTORE_UC;
                            end
                        end else begin
                            nxt_s.chk_left = s_ff.chk_left - 12'h001;
                        end
                    end
                end
            end
            ST_RESTORE: begin
                if (tif.tick) begin
                    if (s_ff.uc_left == 12'h001) begin
                        nxt_s.st = ST_WAIT;
                        nxt_s.restored = 1'b1;
                        nxt_s.irq_ack = 1'b1;
                    end else begin
                        nxt_s.uc_left = s_ff.uc_left - 12'h001;
                    end
                end
            end
            ST_WAIT: begin
                if (svc_done) begin
                    nxt_s.st = ST_EXEC;
                    nxt_s.uc_left = s_ff.total;
                    nxt_s.chk_left = CHK;
                    nxt_s.restart = 1'b1;
                end
            end
            default: begin
                nxt_s = SEQ_RST;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_ff <= SEQ_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ********************************************************
    // outputs
    // ********************************************************
    assign busy = (s_ff.st != ST_IDLE);
    assign done = s_ff.done;
    assign aborted = s_ff.aborted;
    assign restored = s_ff.restored;
    assign restart = s_ff.restart;
    assign irq_ack = s_ff.irq_ack;
    assign restore_acc = s_ff.acc_save;
    assign restore_src = s_ff.src_save;
    assign total_uc = s_ff.total;
    assign lat_uc = s_ff.lat;

    // ********************************************************
    // checks
    // ********************************************************

    // helper counters seen only by the checks
    logic [15:0] rcnt_ff;
    logic [15:0] tcnt_ff;
    word_t snap_ff;
    logic load;
    assign load = (s_ff.st == ST_IDLE && start) || (s_ff.st == ST_WAIT && svc_done);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rcnt_ff <= 16'h0000;
            tcnt_ff <= 16'h0000;
            snap_ff <= 16'h0000;
        end else begin
            rcnt_ff <= (s_ff.st == ST_RESTORE) ? rcnt_ff + 16'h0001 : 16'h0000;
            if (load) begin
                tcnt_ff <= 16'h0000;
            end else if (s_ff.st == ST_EXEC && tif.tick) begin
                tcnt_ff <= tcnt_ff + 16'h0001;
            end
            if (s_ff.st == ST_IDLE && start) begin
                snap_ff <= fp_accumulator_operand;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_exec_length: assert property (done |-> tcnt_ff == 16'(total_uc))
        else $error("execution length differs from total");
    a_mem_added: assert property (
        (s_ff.st == ST_IDLE && start && addr_mode != 3'h0 && dbl && op_class == OP_OTHER
         && sign_case == SG_NA && !trap_any && mem_uc != 8'h00 && base_uc < 12'h100)
        |=> total_uc == $past(base_uc) + 12'($past(mem_uc)))
        else $error("memory time not added");
    a_no_mid_abort: assert property ((s_ff.st == ST_EXEC && !s_ff.arith) |=> !aborted)
        else $error("non-arithmetic instruction aborted");
    a_abort_cause: assert property (aborted |-> $past(irq_req) && $past(s_ff.arith))
        else $error("abort without request");
    a_abort_restore: assert property (aborted |-> s_ff.st == ST_RESTORE ##[1:1000] restored)
        else $error("abort did not enter restore");
    a_restore_value: assert property (restored |-> restore_acc == snap_ff)
        else $error("restored accumulator wrong");
    a_restart_reload: assert property (restart |-> s_ff.uc_left == total_uc && busy)
        else $error("restart did not reload full length");
    a_restore_time: assert property (restored |-> rcnt_ff == 16'(RST_CLKS))
        else $error("restore length wrong");
    a_arith_latency: assert property (
        $rose(busy) && s_ff.arith |-> lat_uc == CHK + RESTORE_UC)
        else $error("latency lacks restore time");
    a_ack_timing: assert property (irq_ack |-> done || restored)
        else $error("interrupt granted mid instruction");

    c_abort: cover property (aborted ##[1:1000] restored);
    c_restart_done: cover property (restart ##[1:1000] done);
    c_plain_done: cover property (done && !s_ff.arith);
    c_ack_at_end: cover property (done && irq_ack);
endmodule
`default_nettype wire

/* File: include/fpt_cfg.svh */
// timing constants for the floating-point execution timer
// assumes a 125 MHz core clock and a 300 ns microcycle
// Functional notes
// - count time in 300 ns microcycles
// - non-register modes add memory reference time
// - other instructions take interrupts only at end
// - arithmetic samples interrupts at check points
// - abort restores accumulator and source operand to entry values
// - restart aborted instruction from its beginning
// - restore takes 6.9 us, counted in latency
// - reported arithmetic latency includes restore time
// - positive result adds 300 ns
// - non-zero result adds another 300 ns
// - rounding overflow adds 3.3 us to load/convert
// - single add/sub align 900 ns plus 1.2 us/step
// - multiply adds 600 ns per multiplier one bit in single precision
// - each normalise shift adds 1.2 us in single precision
// - equal compare adds 1.2 us
// - undefined variable trap adds 2.4 us
// - any trap adds 4.5 us
// - conversion error trap adds 24.3 us
// - underflow trap adds 9.9 us
// - rounding adds 1.2 us in single precision
// - sign cases: positive, negative, negative zero
`ifndef FPT_CFG_SVH
`define FPT_CFG_SVH

// ********************************************************
// clock and microcycle
// ********************************************************
`define CLK_NS 8
`define UCYCLE_NS 300
`define UCYC_CLKS ((`UCYCLE_NS + `CLK_NS - 1) / `CLK_NS)
`define NS2UC(t) ((t) / `UCYCLE_NS)

// ********************************************************
// data-dependent increments and restore time in ns, then check interval and counter limit in microcycles
// ********************************************************
`define T_POS_NS 300
`define T_NZ_NS 300
`define T_RNDOVF_NS 3300
`define T_ALIGN_NS 900
`define T_ALIGN_STEP_NS 1200
`define T_MULBIT_NS 600
`define T_NORM_NS 1200
`define T_CMPEQ_NS 1200
`define T_UNDEF_NS 2400
`define T_TRAP_NS 4500
`define T_CONVERR_NS 24300
`define T_UNFL_NS 9900
`define T_ROUND_NS 1200
`define T_RESTORE_NS 6900
`define CHK_UC_DEF 87
`define UC_MAX 12'hfff

`endif

/* File: include/fpt_pkg.sv */
// types shared by the floating-point execution timer
// assumes fpt_cfg.svh for the numbers
`default_nettype none
package fpt_pkg;
    typedef enum logic [3:0] {
        OP_LOAD, OP_CONV, OP_CMP, OP_ADD, OP_SUB, OP_MUL, OP_DIV, OP_MOD, OP_OTHER
    } op_class_e;
    typedef enum logic [1:0] {SG_NA, SG_POS, SG_NEG_NZ, SG_NEG_ZERO} sign_case_e;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001, ST_EXEC = 4'b0010, ST_RESTORE = 4'b0100, ST_WAIT = 4'b1000
    } seq_state_e;
    typedef logic [11:0] uc_t;
    typedef logic [15:0] word_t;
    typedef struct packed {
        op_class_e op;
        logic dbl;
        logic [2:0] mode;
        logic [7:0] mem_uc;
        uc_t base_uc;
        sign_case_e sign;
        logic undef_flag;
        logic round_ovf;
        logic rounding;
        logic [7:0] exp_diff;
        word_t src;
        logic [5:0] shifts;
        logic cmp_equal;
        logic trap_any;
        logic trap_conv;
        logic trap_unfl;
    } op_info_s;
endpackage
`default_nettype wire

/* File: include/ucycle_if.sv */
// microcycle strobe between the sequencer and its timer
// assumes both ends run on the same clock
`default_nettype none
interface ucycle_if;
    logic run;
    logic tick;
    modport tmr (input run, output tick);
    modport seq (output run, input tick);
endinterface
`default_nettype wire

/* File: logic/ucycle_timer.sv */
// microcycle divider: one tick per microcycle while run is high
// assumes a synchronous active-low reset
`include "fpt_cfg.svh"
`default_nettype none
module ucycle_timer #(
    parameter int unsigned DIV = `UCYC_CLKS
) (
    input wire logic clk,
    input wire logic rst_n,
    ucycle_if.tmr tif
);
    // ********************************************************
    // state
    // ********************************************************
    typedef struct packed {
        logic [15:0] cnt;
    } tmr_s;
    tmr_s st_ff;
    tmr_s nxt_st;
    localparam logic [15:0] LAST = 16'(DIV - 1);

    if (DIV < 1 || DIV > 65535) begin : g_chk
        $error("ucycle_timer: DIV out of range");
    end

    // strobe on the last clock of each microcycle
    assign tif.tick = tif.run && (st_ff.cnt == LAST);

    // count clocks, restart when stopped or wrapped
    always_comb begin
        nxt_st = st_ff;
        if (!tif.run || tif.tick) begin
            nxt_st.cnt = 16'h0000;
        end else begin
            nxt_st.cnt = st_ff.cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule
`default_nettype wire

/* File: sim/irq_partner.sv */
// interrupt source model: raises a request, serves it, ends the service
// assumes the timer's clock and its synchronous active-low reset
`default_nettype none
module irq_partner (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic want_irq,
    input wire logic [7:0] svc_cycles,
    input wire logic irq_ack,
    output logic irq_req,
    output logic svc_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic serving_ff;
    logic [7:0] cnt_ff;
    // request follows want_irq until granted, then a timed service pulse
    always @(posedge clk) begin
        if (!rst_n) begin
            irq_req <= 1'b0;
            svc_done <= 1'b0;
            serving_ff <= 1'b0;
            cnt_ff <= 8'h00;
        end else if (irq_ack) begin
            irq_req <= 1'b0;
            serving_ff <= 1'b1;
            cnt_ff <= svc_cycles;
        end else if (serving_ff) begin
            serving_ff <= (cnt_ff != 8'h00);
            svc_done <= (cnt_ff == 8'h00);
            cnt_ff <= cnt_ff - 8'h01;
        end else begin
            svc_done <= 1'b0;
            irq_req <= want_irq;
        end
    end
endmodule
`default_nettype wire

/* File: sim/fp_exec_timer_tb_top.sv */
// self-checking bench for the floating-point execution timer
// assumes irq_partner on the interrupt side and a short check interval
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("ERROR t=%0t got %0h exp %0h", $time, (g), (e)); end end
module fp_exec_timer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import fpt_pkg::*;
    localparam int CHK_N = 3;
    localparam int DV = 2;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic start = 1'b0;
    op_info_s cur = '0;
    word_t acc = 16'h0000;
    logic want_irq = 1'b0;
    logic [7:0] svc_cycles = 8'h05;
    logic irq_req, svc_done, busy, done, aborted, restored, restart, irq_ack;
    word_t restore_acc, restore_src;
    uc_t total_uc, lat_uc;
    int fail_count = 0;
    int total_checks = 0;
    int cycles = 0;
    int t_ab, t_rs, t_rt, t_ak, t_dn;

    // ****************************************************************
    // clock, design and interrupt model
    // ****************************************************************
    always #4 clk = ~clk;

    fp_exec_timer #(.CHK_UC(CHK_N), .DIV(DV)) u_dut (
        .clk(clk), .rst_n(rst_n), .start(start), .op_class(cur.op), .dbl(cur.dbl),
        .addr_mode(cur.mode), .mem_uc(cur.mem_uc), .base_uc(cur.base_uc),
        .sign_case(cur.sign), .undefined_variable_trap_flag(cur.undef_flag),
        .round_ovf(cur.round_ovf), .rounding(cur.rounding), .exp_diff(cur.exp_diff),
        .fp_source_operand(cur.src), .fp_accumulator_operand(acc),
        .norm_shifts(cur.shifts), .cmp_equal(cur.cmp_equal), .trap_any(cur.trap_any),
        .trap_conv(cur.trap_conv), .trap_underflow(cur.trap_unfl), .irq_req(irq_req),
        .svc_done(svc_done), .busy(busy), .done(done), .aborted(aborted),
        .restored(restored), .restart(restart), .irq_ack(irq_ack),
        .restore_acc(restore_acc), .restore_src(restore_src), .total_uc(total_uc),
        .lat_uc(lat_uc)
    );

    irq_partner u_irq (
        .clk(clk), .rst_n(rst_n), .want_irq(want_irq), .svc_cycles(svc_cycles),
        .irq_ack(irq_ack), .irq_req(irq_req), .svc_done(svc_done)
    );

    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // hang guard: far above the summed length of all scenarios
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            fail_count++;
            complete_run();
        end
    end

    function automatic bit is_arith(op_class_e o);
        return o >= OP_ADD && o <= OP_MOD;
    endfunction

    function automatic bit near(int got, int want);
        return got >= want && got <= want + 2;
    endfunction

    function automatic op_info_s mk(op_class_e op, uc_t base);
        op_info_s i;
        i = '0;
        i.op = op;
        i.base_uc = base;
        return i;
    endfunction

    // expected length in microcycles, built from the increments one by one
    function automatic int exp_total(op_info_s i);
        int t;
        t = i.base_uc;
        if (i.mode != 3'h0) t += i.mem_uc;
        if (i.sign == SG_POS) t += 2;
        if (i.sign == SG_NEG_NZ) t += 1;
        if (i.sign == SG_NEG_ZERO && i.undef_flag) t += 8;
        if (i.round_ovf && (i.op == OP_LOAD || i.op == OP_CONV)) t += 11;
        if (!i.dbl) begin
            t += i.rounding ? 4 : 0;
            t += 4 * i.shifts;
            if (i.op == OP_ADD || i.op == OP_SUB) t += 3 + 4 * i.exp_diff;
            if (i.op == OP_MUL) t += 2 * $countones(i.src);
        end
        if (i.cmp_equal && i.op == OP_CMP) t += 4;
        if (i.trap_any) t += 15;
        if (i.trap_conv && i.op == OP_CONV) t += 81;
        if (i.trap_unfl && is_arith(i.op)) t += 33;
        if (t > 4095) t = 4095;
        if (t < 1) t = 1;
        return t;
    endfunction

    // one instruction: start, alter inputs after the take, time every pulse
    task automatic run_op(op_info_s i, word_t a, bit ab);
        int n;
        int tot;
        int lat;
        tot = exp_total(i);
        lat = is_arith(i.op) ? CHK_N + 23 : tot;
        t_ab = -1;
        t_rs = -1;
        t_rt = -1;
        t_ak = -1;
        t_dn = -1;
        @(negedge clk);
        cur = i;
        acc = a;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        acc = ~a;
        cur.src = ~i.src;
        `CHK(busy, 1'b1)
        `CHK(total_uc, uc_t'(tot))
        `CHK(lat_uc, uc_t'(lat))
        n = 0;
        while (t_dn < 0 && n < 20000) begin
            if (aborted === 1'b1) t_ab = n;
            if (aborted === 1'b1) want_irq = 1'b0;
            if (restored === 1'b1) t_rs = n;
            if (restart === 1'b1) t_rt = n;
            if (irq_ack === 1'b1) t_ak = n;
            if (done === 1'b1) t_dn = n;
            n++;
            @(negedge clk);
        end
        `CHK(t_ab >= 0, ab)
        if (ab) begin
            `CHK(near(t_ab, CHK_N * DV), 1'b1)
            `CHK(near(t_rs - t_ab, 23 * DV - 1), 1'b1)
            `CHK(t_ak, t_rs)
            `CHK(t_rt > t_rs, 1'b1)
            `CHK(near(t_dn - t_rt, tot * DV), 1'b1)
        end else begin
            `CHK(near(t_dn, tot * DV), 1'b1)
        end
        `CHK(busy, 1'b0)
        `CHK(restore_acc, a)
        `CHK(restore_src, i.src)
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_reset();
        `CHK({busy, done, aborted, restored, restart, irq_ack}, 6'h00)
        `CHK({total_uc, lat_uc}, 24'h00_0000)
        $display("test reset done");
    endtask

    task automatic t_base();
        op_info_s i;
        i = mk(OP_OTHER, 12'h00a);
        run_op(i, 16'h1234, 1'b0);
        i.mode = 3'h3;
        i.mem_uc = 8'h05;
        i.dbl = 1'b1;
        run_op(i, 16'h4321, 1'b0);
        run_op(mk(OP_OTHER, 12'h000), 16'h0001, 1'b0);
        i = mk(OP_LOAD, 12'hffa);
        i.trap_any = 1'b1;
        run_op(i, 16'h8000, 1'b0);
        $display("test base done");
    endtask

    task automatic t_sign();
        op_info_s i;
        for (int k = 0; k < 5; k++) begin
            i = mk(OP_LOAD, 12'h01c);
            i.sign = (k > 3) ? SG_NEG_ZERO : sign_case_e'(k[1:0]);
            i.undef_flag = (k == 4);
            run_op(i, 16'h0f0f, 1'b0);
        end
        $display("test sign done");
    endtask

    task automatic t_data();
        op_info_s i;
        i = mk(OP_LOAD, 12'h024);
        i.round_ovf = 1'b1;
        i.rounding = 1'b1;
        run_op(i, 16'h0102, 1'b0);
        i.dbl = 1'b1;
        run_op(i, 16'h0203, 1'b0);
        i = mk(OP_ADD, 12'h079);
        i.exp_diff = 8'h02;
        i.shifts = 6'h03;
        run_op(i, 16'h0304, 1'b0);
        i = mk(OP_MUL, 12'h108);
        i.src = 16'h80f1;
        run_op(i, 16'h0405, 1'b0);
        i = mk(OP_CMP, 12'h041);
        i.cmp_equal = 1'b1;
        run_op(i, 16'h0506, 1'b0);
        i = mk(OP_CONV, 12'h028);
        i.trap_conv = 1'b1;
        run_op(i, 16'h0607, 1'b0);
        i = mk(OP_DIV, 12'h12d);
        i.trap_unfl = 1'b1;
        run_op(i, 16'h0708, 1'b0);
        i = mk(OP_SUB, 12'h07c);
        i.sign = SG_NEG_ZERO;
        i.undef_flag = 1'b1;
        run_op(i, 16'h0809, 1'b0);
        $display("test data done");
    endtask

    task automatic t_abort();
        op_info_s i;
        for (int k = 3; k < 8; k++) begin
            i = mk(op_class_e'(k), 12'h014);
            i.src = 16'h00c3;
            want_irq = 1'b1;
            run_op(i, 16'hbe00 + 16'(k), 1'b1);
        end
        $display("test abort done");
    endtask

    task automatic t_late_irq();
        want_irq = 1'b1;
        run_op(mk(OP_OTHER, 12'h00a), 16'h5a5a, 1'b0);
        `CHK(t_ak, t_dn)
        want_irq = 1'b0;
        repeat (20) @(negedge clk);
        $display("test late irq done");
    endtask

    task automatic t_refuse();
        fork
            run_op(mk(OP_OTHER, 12'h010), 16'h0011, 1'b0);
            begin
                repeat (4) @(negedge clk);
                start = 1'b1;
                cur.base_uc = 12'h020;
                @(negedge clk);
                start = 1'b0;
            end
        join
        `CHK(total_uc, uc_t'(16))
        $display("test refuse done");
    endtask

    // reset for two cycles, then every scenario in turn
    initial begin
        repeat (2) @(negedge clk);
        t_reset();
        rst_n = 1'b1;
        t_base();
        t_sign();
        t_data();
        t_abort();
        t_late_irq();
        t_refuse();
        complete_run();
    end
endmodule
`default_nettype wire
